/* abeu_map.vh */
// Purpose: constants of the arithmetic and branch execute unit
// Assumes: included by abeu_exec.v, not by abeu_alu.v
// Notes:   definitions only
`ifndef ABEU_MAP_VH
`define ABEU_MAP_VH

// status flag bit positions
`define ABEU_FLAG_C        3'd0
`define ABEU_FLAG_Z        3'd1
`define ABEU_FLAG_N        3'd2
`define ABEU_FLAG_V        3'd3
`define ABEU_FLAG_S        3'd4
`define ABEU_FLAG_H        3'd5
`define ABEU_FLAGS_RESET   8'h00
`define ABEU_BYTE_ONES     8'hFF

// operation codes on instr_op
`define ABEU_OP_ADD                  5'h00
`define ABEU_OP_ADD_CARRY            5'h01
`define ABEU_OP_SUB                  5'h02
`define ABEU_OP_SUB_IMMEDIATE        5'h03
`define ABEU_OP_SUB_WITH_CARRY       5'h04
`define ABEU_OP_SUB_CARRY_IMMEDIATE  5'h05
`define ABEU_OP_AND                  5'h06
`define ABEU_OP_AND_IMMEDIATE        5'h07
`define ABEU_OP_OR                   5'h08
`define ABEU_OP_OR_IMMEDIATE         5'h09
`define ABEU_OP_EXCLUSIVE_OR_REGS    5'h0A
`define ABEU_OP_SET_BITS_MASK        5'h0B
`define ABEU_OP_CLEAR_BITS_MASK      5'h0C
`define ABEU_OP_ZERO_MINUS_TEST      5'h0D
`define ABEU_OP_ADD_IMM_WORD         5'h0E
`define ABEU_OP_SUB_IMM_WORD         5'h0F
`define ABEU_OP_INDIRECT_JUMP        5'h10
`define ABEU_OP_INDIRECT_CALL        5'h11
`define ABEU_OP_COMPARE              5'h12
`define ABEU_OP_COMPARE_WITH_CARRY_IN 5'h13
`define ABEU_OP_COMPARE_IMMEDIATE    5'h14
`define ABEU_OP_COMPARE_SKIP_EQUAL   5'h15
`define ABEU_OP_SKIP_IF_REG_BIT_CLEAR 5'h16
`define ABEU_OP_SKIP_IF_REG_BIT_ONE  5'h17
`define ABEU_OP_SKIP_IF_IO_BIT_CLEAR 5'h18
`define ABEU_OP_SKIP_IF_IO_BIT_ONE   5'h19
`define ABEU_OP_BRANCH_FLAG_SET      5'h1A
`define ABEU_OP_BRANCH_FLAG_CLEAR    5'h1B
`define ABEU_OP_BRANCH_CARRY_SET     5'h1C
`define ABEU_OP_BRANCH_CARRY_CLEAR   5'h1D
`define ABEU_OP_BRANCH_ON_EQUAL      5'h1E
`define ABEU_OP_BRANCH_ON_UNEQUAL    5'h1F

// cycles per instruction class
`define ABEU_CYC_WORD      2'd2
`define ABEU_CYC_JUMP      2'd2
`define ABEU_CYC_CALL      2'd3
`define ABEU_CYC_TAKEN     2'd2
`define ABEU_CYC_SKIP_ONE  2'd2
`define ABEU_CYC_SKIP_TWO  2'd3

// register port map
`define ABEU_ADDR_WREG_TOP 6'h1F
`define ABEU_ADDR_FLAGS    6'h20
`define ABEU_ADDR_PC_LO    6'h21
`define ABEU_ADDR_PC_HI    6'h22
`define ABEU_ADDR_STATUS   6'h23
`define ABEU_PC_RESET      16'h0000
`define ABEU_PTR_LO_IDX    5'h1E
`define ABEU_PTR_HI_IDX    5'h1F

`endif

/* abeu_alu.v */
// Purpose: byte adder/subtractor with carry, half-carry and overflow
// Assumes: operands and carry settle combinationally
// Notes:   zero and negative are judged by the caller
`timescale 1ns/1ps
`default_nettype none
module abeu_alu #(
   parameter W = 8
) (
   // operands
   input  wire [W-1:0] a,
   input  wire [W-1:0] b,
   input  wire         cin,
   input  wire         sub,
   // results
   output wire [W-1:0] res,
   output wire         carry,
   output wire         half,
   output wire         ovf
);
   localparam HB = W / 2;

   wire [W:0]  ext_a = {1'b0, a};
   wire [W:0]  ext_b = {1'b0, b};
   wire [W:0]  ext_c = {{W{1'b0}}, cin};
   wire [HB:0] nib_a = {1'b0, a[HB-1:0]};
   wire [HB:0] nib_b = {1'b0, b[HB-1:0]};
   wire [HB:0] nib_c = {{HB{1'b0}}, cin};

   // borrow shows as the top bit going high on subtraction
   wire [W:0]  full = sub ? (ext_a - ext_b - ext_c) : (ext_a + ext_b + ext_c);
   wire [HB:0] nib  = sub ? (nib_a - nib_b - nib_c) : (nib_a + nib_b + nib_c);

   assign res   = full[W-1:0];
   assign carry = full[W];
   assign half  = nib[HB];
   // overflow: sign of result disagrees with the operand signs
   assign ovf   = sub ? ((a[W-1] & ~b[W-1] & ~res[W-1]) | (~a[W-1] & b[W-1] & res[W-1]))
                      : ((a[W-1] & b[W-1] & ~res[W-1]) | (~a[W-1] & ~b[W-1] & res[W-1]));
endmodule
`default_nettype wire

/* abeu_exec.v */
// Purpose: executes arithmetic, logic, compare, skip and branch operations
// Assumes: instruction fields arrive decoded, synchronous to clk (50 MHz)
// Notes:   one instruction accepted when instr_ready is high
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "abeu_map.vh"
module abeu_exec (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // decoded instruction
   input  wire        instr_valid,
   input  wire [4:0]  instr_op,
   input  wire [4:0]  instr_rd,
   input  wire [4:0]  instr_rr,
   input  wire [7:0]  instr_imm,
   input  wire [2:0]  instr_bit,
   input  wire [11:0] instr_ofs,
   input  wire        next_long,
   input  wire [7:0]  io_value,
   output reg         instr_ready,
   // return address push for calls
   output reg         push_valid,
   output reg  [15:0] push_addr,
   // program counter and flags
   output reg  [15:0] pc,
   output reg  [7:0]  status_flags_reg,
   // register port
   input  wire [5:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata
);
   localparam ST_RUN  = 2'b01;
   localparam ST_HOLD = 2'b10;

   reg  [7:0]  wreg [0:31];
   reg  [1:0]  state;
   reg  [1:0]  hold_cnt;
   integer     i;

   wire        accept = instr_valid & instr_ready;
   wire [7:0]  op_a   = wreg[instr_rd];
   wire [7:0]  op_r   = wreg[instr_rr];
   wire [4:0]  pair_lo = {instr_rd[4:1], 1'b0};
   wire [4:0]  pair_hi = {instr_rd[4:1], 1'b1};
   wire [15:0] pair   = {wreg[pair_hi], wreg[pair_lo]};
   wire [15:0] ptr    = {wreg[`ABEU_PTR_HI_IDX], wreg[`ABEU_PTR_LO_IDX]};
   wire [15:0] pc_inc = pc + 16'h0001;
   wire [15:0] pc_rel = pc + {{4{instr_ofs[11]}}, instr_ofs} + 16'h0001;
   wire        c_in   = status_flags_reg[`ABEU_FLAG_C];

   // operand and carry selection for the byte adder
   reg         use_imm;
   reg         use_carry;
   reg         is_add;
   always @* begin
      use_imm = (instr_op == `ABEU_OP_SUB_IMMEDIATE) |
                (instr_op == `ABEU_OP_SUB_CARRY_IMMEDIATE) |
                (instr_op == `ABEU_OP_COMPARE_IMMEDIATE);
      use_carry = (instr_op == `ABEU_OP_ADD_CARRY) |
                  (instr_op == `ABEU_OP_SUB_WITH_CARRY) |
                  (instr_op == `ABEU_OP_SUB_CARRY_IMMEDIATE) |
                  (instr_op == `ABEU_OP_COMPARE_WITH_CARRY_IN);
      is_add = (instr_op == `ABEU_OP_ADD) | (instr_op == `ABEU_OP_ADD_CARRY);
   end

   wire [7:0]  alu_b = use_imm ? instr_imm : op_r;
   wire [7:0]  alu_res;
   wire        alu_c;
   wire        alu_h;
   wire        alu_v;

   abeu_alu #(
      .W     (8)
   ) u_alu (
      .a     (op_a),
      .b     (alu_b),
      .cin   (use_carry & c_in),
      .sub   (~is_add),
      .res   (alu_res),
      .carry (alu_c),
      .half  (alu_h),
      .ovf   (alu_v)
   );

   // word arithmetic on a register pair, immediate zero-extended
   wire [16:0] word_add = {1'b0, pair} + {9'h000, instr_imm};
   wire [16:0] word_sub = {1'b0, pair} - {9'h000, instr_imm};

   // next-state decision for the accepted instruction
   reg  [7:0]  next_flags;
   reg  [15:0] next_pc;
   reg  [7:0]  next_val;
   reg         next_wr;
   reg         next_word_wr;
   reg  [15:0] next_word;
   reg  [1:0]  next_cycles;
   reg         next_push;
   reg  [7:0]  logic_res;
   reg         skip;
   reg         taken;
   reg         word_v;
   always @* begin
      next_flags   = status_flags_reg;
      next_pc      = pc_inc;
      next_val     = alu_res;
      next_wr      = 1'b0;
      next_word_wr = 1'b0;
      next_word    = word_add[15:0];
      next_cycles  = 2'd1;
      next_push    = 1'b0;
      logic_res    = 8'h00;
      skip         = 1'b0;
      taken        = 1'b0;
      word_v       = 1'b0;
      case (instr_op)
         `ABEU_OP_ADD, `ABEU_OP_ADD_CARRY, `ABEU_OP_SUB, `ABEU_OP_SUB_IMMEDIATE,
         `ABEU_OP_SUB_WITH_CARRY, `ABEU_OP_SUB_CARRY_IMMEDIATE: begin
            next_wr = 1'b1;
            next_flags[`ABEU_FLAG_Z] = (alu_res == 8'h00);
            next_flags[`ABEU_FLAG_C] = alu_c;
            next_flags[`ABEU_FLAG_N] = alu_res[7];
            next_flags[`ABEU_FLAG_V] = alu_v;
            next_flags[`ABEU_FLAG_H] = alu_h;
         end
         `ABEU_OP_COMPARE, `ABEU_OP_COMPARE_WITH_CARRY_IN, `ABEU_OP_COMPARE_IMMEDIATE: begin
            // difference is judged but never stored
            next_flags[`ABEU_FLAG_Z] = (alu_res == 8'h00);
            next_flags[`ABEU_FLAG_C] = alu_c;
            next_flags[`ABEU_FLAG_N] = alu_res[7];
            next_flags[`ABEU_FLAG_V] = alu_v;
            next_flags[`ABEU_FLAG_H] = alu_h;
         end
         `ABEU_OP_AND, `ABEU_OP_AND_IMMEDIATE, `ABEU_OP_OR, `ABEU_OP_OR_IMMEDIATE,
         `ABEU_OP_EXCLUSIVE_OR_REGS, `ABEU_OP_SET_BITS_MASK, `ABEU_OP_CLEAR_BITS_MASK,
         `ABEU_OP_ZERO_MINUS_TEST: begin
            case (instr_op)
               `ABEU_OP_AND:               logic_res = op_a & op_r;
               `ABEU_OP_AND_IMMEDIATE:     logic_res = op_a & instr_imm;
               `ABEU_OP_OR:                logic_res = op_a | op_r;
               `ABEU_OP_OR_IMMEDIATE:      logic_res = op_a | instr_imm;
               `ABEU_OP_EXCLUSIVE_OR_REGS: logic_res = op_a ^ op_r;
               `ABEU_OP_SET_BITS_MASK:     logic_res = op_a | instr_imm;
               `ABEU_OP_CLEAR_BITS_MASK:   logic_res = op_a & (`ABEU_BYTE_ONES - instr_imm);
               default:                    logic_res = op_a & op_a;
            endcase
            next_wr  = 1'b1;
            next_val = logic_res;
            // carry and half-carry are left alone by logic operations
            next_flags[`ABEU_FLAG_Z] = (logic_res == 8'h00);
            next_flags[`ABEU_FLAG_N] = logic_res[7];
            next_flags[`ABEU_FLAG_V] = 1'b0;
         end
         `ABEU_OP_ADD_IMM_WORD, `ABEU_OP_SUB_IMM_WORD: begin
            next_word_wr = 1'b1;
            next_cycles  = `ABEU_CYC_WORD;
            if (instr_op == `ABEU_OP_ADD_IMM_WORD) begin
               next_word = word_add[15:0];
               next_flags[`ABEU_FLAG_C] = word_add[16];
               word_v = ~pair[15] & word_add[15];
            end else begin
               next_word = word_sub[15:0];
               next_flags[`ABEU_FLAG_C] = word_sub[16];
               word_v = pair[15] & ~word_sub[15];
            end
            next_flags[`ABEU_FLAG_Z] = (next_word == 16'h0000);
            next_flags[`ABEU_FLAG_N] = next_word[15];
            next_flags[`ABEU_FLAG_V] = word_v;
            next_flags[`ABEU_FLAG_S] = next_word[15] ^ word_v;
         end
         `ABEU_OP_INDIRECT_JUMP: begin
            next_pc     = ptr;
            next_cycles = `ABEU_CYC_JUMP;
         end
         `ABEU_OP_INDIRECT_CALL: begin
            next_pc     = ptr;
            next_cycles = `ABEU_CYC_CALL;
            next_push   = 1'b1;
         end
         `ABEU_OP_COMPARE_SKIP_EQUAL:    skip = (op_a == op_r);
         `ABEU_OP_SKIP_IF_REG_BIT_CLEAR: skip = ~op_r[instr_bit];
         `ABEU_OP_SKIP_IF_REG_BIT_ONE:   skip = op_r[instr_bit];
         `ABEU_OP_SKIP_IF_IO_BIT_CLEAR:  skip = ~io_value[instr_bit];
         `ABEU_OP_SKIP_IF_IO_BIT_ONE:    skip = io_value[instr_bit];
         `ABEU_OP_BRANCH_FLAG_SET:   taken = status_flags_reg[instr_bit];
         `ABEU_OP_BRANCH_FLAG_CLEAR: taken = ~status_flags_reg[instr_bit];
         `ABEU_OP_BRANCH_CARRY_SET:  taken = status_flags_reg[`ABEU_FLAG_C];
         `ABEU_OP_BRANCH_CARRY_CLEAR: taken = ~status_flags_reg[`ABEU_FLAG_C];
         `ABEU_OP_BRANCH_ON_EQUAL:   taken = status_flags_reg[`ABEU_FLAG_Z];
         `ABEU_OP_BRANCH_ON_UNEQUAL: taken = ~status_flags_reg[`ABEU_FLAG_Z];
         default: next_wr = 1'b0;
      endcase
      // skipped length decides both PC step and cost
      if (skip) begin
         next_pc     = next_long ? (pc + 16'h0003) : (pc + 16'h0002);
         next_cycles = next_long ? `ABEU_CYC_SKIP_TWO : `ABEU_CYC_SKIP_ONE;
      end
      // an untaken branch keeps the default step of one word
      if (taken) begin
         next_pc     = pc_rel;
         next_cycles = `ABEU_CYC_TAKEN;
      end
   end

   // sequencer, register file, flags and PC
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state            <= ST_RUN;
         hold_cnt         <= 2'd0;
         instr_ready      <= 1'b0;
         push_valid       <= 1'b0;
         push_addr        <= 16'h0000;
         pc               <= `ABEU_PC_RESET;
         status_flags_reg <= `ABEU_FLAGS_RESET;
         reg_rdata        <= 8'h00;
         for (i = 0; i < 32; i = i + 1) begin
            wreg[i] <= 8'h00;
         end
      end else begin
         push_valid <= 1'b0;
         // software access; instruction writes below win a clash
         if (reg_wr) begin
            if (reg_addr <= `ABEU_ADDR_WREG_TOP) begin
               wreg[reg_addr[4:0]] <= reg_wdata;
            end else if (reg_addr == `ABEU_ADDR_FLAGS) begin
               status_flags_reg <= reg_wdata;
            end else if (reg_addr == `ABEU_ADDR_PC_LO && state == ST_RUN) begin
               pc[7:0] <= reg_wdata;
            end else if (reg_addr == `ABEU_ADDR_PC_HI && state == ST_RUN) begin
               pc[15:8] <= reg_wdata;
            end
         end
         if (reg_rd) begin
            if (reg_addr <= `ABEU_ADDR_WREG_TOP) begin
               reg_rdata <= wreg[reg_addr[4:0]];
            end else if (reg_addr == `ABEU_ADDR_FLAGS) begin
               reg_rdata <= status_flags_reg;
            end else if (reg_addr == `ABEU_ADDR_PC_LO) begin
               reg_rdata <= pc[7:0];
            end else if (reg_addr == `ABEU_ADDR_PC_HI) begin
               reg_rdata <= pc[15:8];
            end else if (reg_addr == `ABEU_ADDR_STATUS) begin
               reg_rdata <= {7'h00, (state == ST_HOLD)};
            end else begin
               reg_rdata <= 8'h00;
            end
         end else begin
            reg_rdata <= 8'h00;
         end
         case (state)
            ST_RUN: begin
               instr_ready <= 1'b1;
               if (accept) begin
                  pc               <= next_pc;
                  status_flags_reg <= next_flags;
                  if (next_wr) begin
                     wreg[instr_rd] <= next_val;
                  end
                  if (next_word_wr) begin
                     wreg[pair_lo] <= next_word[7:0];
                     wreg[pair_hi] <= next_word[15:8];
                  end
                  if (next_push) begin
                     push_valid <= 1'b1;
                     push_addr  <= pc_inc;
                  end
                  // multi-cycle classes hold off the next instruction
                  if (next_cycles > 2'd1) begin
                     state       <= ST_HOLD;
                     hold_cnt    <= next_cycles - 2'd1;
                     instr_ready <= 1'b0;
                  end
               end
            end
            ST_HOLD: begin
               hold_cnt <= hold_cnt - 2'd1;
               if (hold_cnt == 2'd1) begin
                  state       <= ST_RUN;
                  instr_ready <= 1'b1;
               end
            end
            default: begin
               state       <= ST_RUN;
               instr_ready <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* abeu_prog_mem.sv */
// Purpose: program memory model offering decoded instruction words
// Assumes: issue is called just after a rising clk edge
// Notes:   released fields show inverted values so stale data is never trusted
`timescale 1ns/1ps
`default_nettype none
module abeu_prog_mem (
   // clock and handshake
   input  wire logic        clk,
   input  wire logic        instr_ready,
   // decoded instruction word
   output var  logic        instr_valid,
   output var  logic [4:0]  instr_op,
   output var  logic [4:0]  instr_rd,
   output var  logic [4:0]  instr_rr,
   output var  logic [7:0]  instr_imm,
   output var  logic [2:0]  instr_bit,
   output var  logic [11:0] instr_ofs,
   output var  logic        next_long,
   output var  logic [7:0]  io_value
);
   // idle until the first offer
   initial begin
      instr_valid = 1'b0;
      {instr_op, instr_rd, instr_rr, instr_imm, instr_bit, instr_ofs, next_long, io_value} = '0;
   end

   // offer one word, hold it until taken, then count cycles until the next slot
   task automatic issue(input logic [4:0] op, input logic [4:0] rd, input logic [4:0] rr,
                        input logic [7:0] imm, input logic [2:0] b, input logic [11:0] ofs,
                        input logic lng, input logic [7:0] io, output integer cyc);
      logic [46:0] w;
      integer      k;
      begin
         w = {op, rd, rr, imm, b, ofs, lng, io};
         instr_valid <= 1'b1;
         {instr_op, instr_rd, instr_rr, instr_imm, instr_bit, instr_ofs, next_long, io_value} <= w;
         k = 0;
         do begin
            @(posedge clk);
            k = k + 1;
         end while (!instr_ready && k < 8);
         // bounded waits: a stuck ready shows up as a wrong cycle count
         instr_valid <= 1'b0;
         {instr_op, instr_rd, instr_rr, instr_imm, instr_bit, instr_ofs, next_long, io_value} <= ~w;
         cyc = 0;
         do begin
            @(posedge clk);
            cyc = cyc + 1;
         end while (!instr_ready && cyc < 8);
      end
   endtask
endmodule
`default_nettype wire

/* abeu_exec_sva.sv */
// Purpose: timing and flag checks on the execute unit's instruction port
// Assumes: one clock, asynchronous reset
// Notes:   register contents are not visible here; the bench reads them back
`timescale 1ns/1ps
`default_nettype none
`include "abeu_map.vh"
module abeu_exec_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // instruction port
   input wire logic        instr_valid,
   input wire logic [4:0]  instr_op,
   input wire logic [2:0]  instr_bit,
   input wire logic [11:0] instr_ofs,
   input wire logic        next_long,
   input wire logic [7:0]  io_value,
   input wire logic        instr_ready,
   // results
   input wire logic        push_valid,
   input wire logic [15:0] push_addr,
   input wire logic [15:0] pc,
   input wire logic [7:0]  status_flags_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // decoded views of the offered word
   wire        acc     = instr_valid && instr_ready;
   wire        is_br   = instr_op[4:3] == 2'b11 && instr_op[2:1] != 2'b00;
   wire        is_io   = instr_op[4:1] == 4'b1100;
   wire        flag    = (instr_op[2:1] == 2'b01) ? status_flags_reg[instr_bit] :
                         ((instr_op[2:1] == 2'b10) ? status_flags_reg[`ABEU_FLAG_C]
                                                   : status_flags_reg[`ABEU_FLAG_Z]);
   wire        br_go   = flag ^ instr_op[0];
   wire        io_go   = io_value[instr_bit] ^ ~instr_op[0];
   wire [15:0] io_step = io_go ? (next_long ? 16'h0003 : 16'h0002) : 16'h0001;
   wire [15:0] ofs_x   = {{4{instr_ofs[11]}}, instr_ofs};
   wire        is_log  = instr_op >= `ABEU_OP_AND && instr_op <= `ABEU_OP_ZERO_MINUS_TEST;
   wire        is_alu  = instr_op <= `ABEU_OP_ZERO_MINUS_TEST ||
                         (instr_op >= `ABEU_OP_COMPARE && instr_op <= `ABEU_OP_COMPARE_IMMEDIATE);
   wire        is_word = instr_op == `ABEU_OP_ADD_IMM_WORD || instr_op == `ABEU_OP_SUB_IMM_WORD;

   // cycle counts, program counter moves and flags per instruction class
   chk_alu_one_cycle: assert property (
      acc && is_alu |=> instr_ready && pc == $past(pc) + 16'h0001)
      else $error("one-cycle op wrong");
   chk_logic_flags: assert property (
      acc && is_log |=> (status_flags_reg & 8'hF1) == ($past(status_flags_reg) & 8'hF1)
      && !status_flags_reg[`ABEU_FLAG_V]) else $error("logic op flags");
   chk_word_cycles: assert property (
      acc && is_word |=> !instr_ready && (status_flags_reg[`ABEU_FLAG_S] == (status_flags_reg[
      `ABEU_FLAG_N] ^ status_flags_reg[`ABEU_FLAG_V])) ##1 instr_ready) else $error("word op");
   chk_jump_cycles: assert property (
      acc && instr_op == `ABEU_OP_INDIRECT_JUMP |=> !instr_ready && $stable(status_flags_reg)
      ##1 instr_ready) else $error("jump wrong");
   chk_call_push: assert property (
      acc && instr_op == `ABEU_OP_INDIRECT_CALL |=> push_valid && push_addr == $past(pc) + 16'h0001
      && !instr_ready ##1 !push_valid && !instr_ready ##1 instr_ready) else $error("call wrong");
   chk_branch_taken: assert property (
      acc && is_br && br_go |=> pc == $past(pc) + $past(ofs_x) + 16'h0001 && !instr_ready
      ##1 instr_ready) else $error("taken branch wrong");
   chk_branch_fall: assert property (
      acc && is_br && !br_go |=> pc == $past(pc) + 16'h0001 && instr_ready
      && $stable(status_flags_reg)) else $error("untaken branch moved wrongly");
   chk_io_skip_pc: assert property (
      acc && is_io |=> pc == $past(pc) + $past(io_step)) else $error("io skip pc wrong");
   chk_skip_long_cost: assert property (
      acc && is_io && io_go && next_long |=> !instr_ready [*2] ##1 instr_ready)
      else $error("long skip cost");
endmodule
bind abeu_exec abeu_exec_sva i_abeu_exec_sva (.*);
`default_nettype wire

/* tb.sv */
// Purpose: self-checking bench for the execute unit
// Assumes: program memory model feeds the instruction port
// Notes:   results and flags are read back over the register port
`timescale 1ns/1ps
`default_nettype none
`include "abeu_map.vh"
module tb;
   // clock, reset and register port
   logic        clk;
   logic        rst;
   logic [5:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   wire  [7:0]  reg_rdata;
   // instruction port
   wire         instr_valid, instr_ready, next_long;
   wire  [4:0]  instr_op, instr_rd, instr_rr;
   wire  [7:0]  instr_imm, io_value;
   wire  [2:0]  instr_bit;
   wire  [11:0] instr_ofs;
   // bookkeeping
   integer      n_errors, checked, ncyc, tick, i;
   logic [4:0]  o;
   logic [7:0]  f;
   logic        go;
   logic [15:0] exp;

   abeu_exec i_abeu_exec (.*, .push_valid(), .push_addr(), .pc(), .status_flags_reg());
   abeu_prog_mem i_abeu_prog_mem (.*);

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // hang guard, far above the run's length
   always @(posedge clk) begin
      tick = tick + 1;
      if (tick == 6000) begin
         n_errors = n_errors + 1;
         test_done();
      end
   end

   task automatic test_done;
      begin
         $display("mismatches %0d of %0d checks", n_errors, checked);
         if (n_errors == 0 && checked > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] want);
      begin
         checked = checked + 1;
         if (seen !== want) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %s expected %h seen %h", nm, want, seen);
         end
      end
   endtask

   // one-cycle strobe, then a quiet edge
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      begin
         reg_addr  <= a;
         reg_wdata <= d;
         reg_wr    <= 1'b1;
         @(posedge clk);
         reg_wr    <= 1'b0;
         @(posedge clk);
      end
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [5:0] a, input logic [7:0] want);
      begin
         reg_addr <= a;
         reg_rd   <= 1'b1;
         @(posedge clk);
         reg_rd   <= 1'b0;
         #1;
         check("reg_rdata", {8'h00, reg_rdata}, {8'h00, want});
         @(posedge clk);
      end
   endtask

   task automatic setpc(input logic [15:0] v);
      begin
         wr(`ABEU_ADDR_PC_LO, v[7:0]);
         wr(`ABEU_ADDR_PC_HI, v[15:8]);
      end
   endtask

   task automatic chkpc(input logic [15:0] v);
      begin
         rd(`ABEU_ADDR_PC_LO, v[7:0]);
         rd(`ABEU_ADDR_PC_HI, v[15:8]);
      end
   endtask

   // byte op on r1 with r2; b is the immediate too
   task automatic byte_op(input logic [4:0] op, input logic [7:0] a, b, f0, res, fe);
      begin
         wr(6'h01, a);
         wr(6'h02, b);
         wr(`ABEU_ADDR_FLAGS, f0);
         i_abeu_prog_mem.issue(op, 5'h01, 5'h02, b, 3'h0, 12'h000, 1'b0, 8'h00, ncyc);
         check("cycles", ncyc[15:0], 16'h0001);
         rd(6'h01, res);
         rd(`ABEU_ADDR_FLAGS, fe);
      end
   endtask

   // word op on the pair r25:r24, or indirect transfer through r31:r30
   task automatic pair_op(input logic [4:0] op, input logic [5:0] lo, input logic [15:0] v,
      input logic [7:0] imm, f0, input logic [15:0] res, input logic [7:0] fe, input integer n);
      begin
         wr(lo, v[7:0]);
         wr(lo + 6'h01, v[15:8]);
         wr(`ABEU_ADDR_FLAGS, f0);
         i_abeu_prog_mem.issue(op, lo[4:0], 5'h00, imm, 3'h0, 12'h000, 1'b0, 8'h00, ncyc);
         check("cycles", ncyc[15:0], n[15:0]);
         if (lo == 6'h1E)
            chkpc(res);
         else begin
            rd(lo, res[7:0]);
            rd(lo + 6'h01, res[15:8]);
         end
         rd(`ABEU_ADDR_FLAGS, fe);
      end
   endtask

   initial begin
      {rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 16'h0000};
      {n_errors, checked, tick} = {32'd0, 32'd0, 32'd0};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      byte_op(`ABEU_OP_ADD, 8'h0F, 8'h01, 8'hD0, 8'h10, 8'hF0);
      byte_op(`ABEU_OP_ADD_CARRY, 8'h80, 8'h80, 8'h01, 8'h01, 8'h09);
      byte_op(`ABEU_OP_SUB, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h25);
      byte_op(`ABEU_OP_SUB_IMMEDIATE, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h28);
      byte_op(`ABEU_OP_SUB_WITH_CARRY, 8'h10, 8'h01, 8'h01, 8'h0E, 8'h20);
      byte_op(`ABEU_OP_SUB_CARRY_IMMEDIATE, 8'h01, 8'h01, 8'h01, 8'hFF, 8'h25);
      byte_op(`ABEU_OP_AND, 8'hF0, 8'h0F, 8'h2D, 8'h00, 8'h23);
      byte_op(`ABEU_OP_AND_IMMEDIATE, 8'hFF, 8'h80, 8'h08, 8'h80, 8'h04);
      byte_op(`ABEU_OP_OR, 8'h80, 8'h01, 8'h00, 8'h81, 8'h04);
      byte_op(`ABEU_OP_OR_IMMEDIATE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02);
      byte_op(`ABEU_OP_EXCLUSIVE_OR_REGS, 8'h55, 8'h55, 8'h01, 8'h00, 8'h03);
      byte_op(`ABEU_OP_SET_BITS_MASK, 8'h01, 8'h30, 8'h04, 8'h31, 8'h00);
      byte_op(`ABEU_OP_CLEAR_BITS_MASK, 8'hFF, 8'h0F, 8'h00, 8'hF0, 8'h04);
      byte_op(`ABEU_OP_ZERO_MINUS_TEST, 8'h80, 8'h80, 8'h0A, 8'h80, 8'h04);
      byte_op(`ABEU_OP_COMPARE, 8'h10, 8'h20, 8'h00, 8'h10, 8'h05);
      byte_op(`ABEU_OP_COMPARE_WITH_CARRY_IN, 8'h20, 8'h1F, 8'h01, 8'h20, 8'h22);
      byte_op(`ABEU_OP_COMPARE_IMMEDIATE, 8'h7F, 8'hFF, 8'h00, 8'h7F, 8'h0D);
      pair_op(`ABEU_OP_ADD_IMM_WORD, 6'h18, 16'hFFFF, 8'h01, 8'h00, 16'h0000, 8'h03, 2);
      pair_op(`ABEU_OP_SUB_IMM_WORD, 6'h18, 16'h8000, 8'h01, 8'h20, 16'h7FFF, 8'h38, 2);
      pair_op(`ABEU_OP_INDIRECT_JUMP, 6'h1E, 16'h1234, 8'h00, 8'h15, 16'h1234, 8'h15, 2);
      pair_op(`ABEU_OP_INDIRECT_CALL, 6'h1E, 16'h0ABC, 8'h00, 8'h2A, 16'h0ABC, 8'h2A, 3);
      // every branch flavour, taken and not, with a backward offset
      for (i = 0; i < 12; i = i + 1) begin
         o = `ABEU_OP_BRANCH_FLAG_SET + {2'b00, i[3:1]};
         f = i[0] ? 8'h09 : 8'h02;
         go = f[(o[2:1] == 2'b01) ? 3 : ((o[2:1] == 2'b10) ? `ABEU_FLAG_C : `ABEU_FLAG_Z)] ^ o[0];
         exp = go ? 16'h00F1 : 16'h0101;
         setpc(16'h0100);
         wr(`ABEU_ADDR_FLAGS, f);
         i_abeu_prog_mem.issue(o, 5'h00, 5'h00, 8'h00, 3'h3, 12'hFF0, 1'b0, 8'h00, ncyc);
         check("cycles", ncyc[15:0], go ? 16'h0002 : 16'h0001);
         chkpc(exp);
         rd(`ABEU_ADDR_FLAGS, f);
      end
      // every skip flavour, condition true and false, before short and long words
      wr(6'h01, 8'h5A);
      for (i = 0; i < 20; i = i + 1) begin
         o = `ABEU_OP_COMPARE_SKIP_EQUAL + {2'b00, i[4:2]};
         f = i[0] ? 8'h5A : 8'hA5;
         go = i[0] ^ (o == `ABEU_OP_SKIP_IF_REG_BIT_CLEAR || o == `ABEU_OP_SKIP_IF_IO_BIT_CLEAR);
         exp = 16'h0200 + (go ? 16'h0002 + {15'h0000, i[1]} : 16'h0001);
         wr(6'h02, f);
         setpc(16'h0200);
         i_abeu_prog_mem.issue(o, 5'h01, 5'h02, 8'h00, 3'h3, 12'h000, i[1], f, ncyc);
         check("cycles", ncyc[15:0], exp - 16'h0200);
         chkpc(exp);
      end
      // unmapped place reads zero; a second reset clears pc and flags
      wr(6'h30, 8'hAA);
      rd(6'h30, 8'h00);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chkpc(`ABEU_PC_RESET);
      rd(`ABEU_ADDR_FLAGS, `ABEU_FLAGS_RESET);
      test_done();
   end
endmodule
`default_nettype wire
